// [arc_far_end.sv]
`timescale 1ns/100ps
// Protection trip logic and breaker contacts
module arc_far_end (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_resetn,
  // Bench control
  input wire logic i_go,
  input wire logic i_no_trip,
  input wire logic i_cb_ok,
  // From sequencer
  input wire logic i_close_command,
  // To sequencer
  output logic o_start,
  output logic o_trip,
  output logic o_open,
  output logic o_ready
);
  // Fault age in clocks, 0 = quiet
  logic [4:0] age;
  // Fault progress, saturates so no wrap
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) age <= 5'h00;
    else if (i_go) age <= 5'h01;
    else if (age != 5'h00 && age != 5'h1f) age <= age + 5'h01;
  end
  // Pickup spans the fault
  assign o_start = (age != 5'h00) && (age < 5'h0d);
  // Short trip so the start limit is met
  assign o_trip = !i_no_trip && (age >= 5'h03) && (age < 5'h09);
  // Poles open on trip, shut on close command
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) o_open <= 1'b0;
    else if (o_trip && age == 5'h04) o_open <= 1'b1;
    else if (i_close_command) o_open <= 1'b0;
  end
  // Mechanism ready to close only while the bench holds i_cb_ok
  assign o_ready = i_cb_ok;
endmodule : arc_far_end

// [arc_pkg.sv]
// Shared constants for the reclosing sequencer
package arc_pkg;
  // Clock and processing tick
  localparam int CLK_PERIOD_NS = 10;
  localparam int TICK_PERIOD_NS = 1000000;
  localparam int TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;
  // Widths
  localparam int TW = 16;
  localparam int AW = 7;
  // Register byte offsets
  localparam logic [6:0] OFS_CTRL = 7'h00;
  localparam logic [6:0] OFS_ACTION = 7'h04;
  localparam logic [6:0] OFS_MAXST = 7'h08;
  localparam logic [6:0] OFS_RECLAIM = 7'h0c;
  localparam logic [6:0] OFS_CBTO = 7'h10;
  localparam logic [6:0] OFS_DYNBLK = 7'h14;
  localparam logic [6:0] OFS_CLOSE = 7'h18;
  localparam logic [6:0] OFS_MANUAL = 7'h1c;
  localparam logic [6:0] OFS_DEAD1P = 7'h20;
  localparam logic [6:0] OFS_DEAD3P = 7'h30;
  localparam logic [6:0] OFS_STATUS = 7'h40;
  // Control word fields
  localparam int CTRL_OP_BIT = 0;
  localparam int CTRL_SHOT_LSB = 1;
  localparam int CTRL_SEL_BIT = 4;
  localparam logic [2:0] SHOT_MAX = 3'h4;
  // Reset values
  localparam logic [15:0] CTRL_RST = 16'h0000;
  localparam logic [15:0] TIME_RST = 16'h0064;
  // Status word fields
  localparam int STAT_SHOT_LSB = 4;
  localparam int STAT_RUN_BIT = 8;
  localparam int STAT_DYN_BIT = 9;
  localparam int STAT_CLOSE_BIT = 10;
  localparam int STAT_3PH_BIT = 11;
  // Bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Sequencer states
  typedef enum logic [3:0] {
    ST_IDLE, ST_ACTION, ST_TRIP, ST_DEAD, ST_CBWAIT,
    ST_RECLAIM, ST_DYNBLK, ST_MANBLK
  } arc_state_t;
endpackage : arc_pkg

// [arc_seq.sv]
// Chosen here: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/100ps
module arc_seq #(
  parameter int TICK_CYCLES = arc_pkg::TICK_CYCLES
) (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_resetn,
  // AXI4-Lite write address
  input wire logic i_s_axi_awvalid,
  output logic o_s_axi_awready,
  input wire logic [arc_pkg::AW-1:0] i_s_axi_awaddr,
  // AXI4-Lite write data
  input wire logic i_s_axi_wvalid,
  output logic o_s_axi_wready,
  input wire logic [31:0] i_s_axi_wdata,
  input wire logic [3:0] i_s_axi_wstrb,
  // AXI4-Lite write response
  output logic o_s_axi_bvalid,
  input wire logic i_s_axi_bready,
  output logic [1:0] o_s_axi_bresp,
  // AXI4-Lite read address
  input wire logic i_s_axi_arvalid,
  output logic o_s_axi_arready,
  input wire logic [arc_pkg::AW-1:0] i_s_axi_araddr,
  // AXI4-Lite read data
  output logic o_s_axi_rvalid,
  input wire logic i_s_axi_rready,
  output logic [31:0] o_s_axi_rdata,
  output logic [1:0] o_s_axi_rresp,
  // Binary inputs from protection logic
  input wire logic i_protection_start_in,
  input wire logic i_reclose_trigger_in,
  input wire logic i_breaker_open_in,
  input wire logic i_breaker_ready_in,
  input wire logic i_reclose_block_in,
  input wire logic i_manual_close_in,
  input wire logic i_dead_time_shortcut_in,
  input wire logic i_three_phase_trip_in,
  input wire logic i_general_block_in,
  // Status outputs
  output logic o_close_command,
  output logic o_sequence_in_progress,
  output logic o_dynamic_blocked,
  output logic o_reclose_disabled,
  output logic [1:0] o_shot_number
);
  import arc_pkg::*;

  localparam int NIN = 9; // Synchronised inputs

  // Input synchronisers
  logic [NIN-1:0] pin_raw; // Raw pins
  logic [NIN-1:0] sync1; // First stage only
  logic [NIN-1:0] sync2; // Safe to use
  assign pin_raw = {i_general_block_in, i_three_phase_trip_in,
    i_dead_time_shortcut_in, i_manual_close_in, i_reclose_block_in,
    i_breaker_ready_in, i_breaker_open_in, i_reclose_trigger_in,
    i_protection_start_in};

  // Two flops before any logic reads a pin
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      sync1 <= '0;
      sync2 <= '0;
    end else begin
      sync1 <= pin_raw;
      sync2 <= sync1;
    end
  end

  // Named synchronised inputs
  wire pstart = sync2[0]; // Protection pickup
  wire trip = sync2[1]; // Trip trigger
  wire cb_open = sync2[2]; // Any pole open
  wire cb_ready = sync2[3]; // Breaker can close
  wire blk_in = sync2[4]; // User block
  wire man_cl = sync2[5]; // Manual close
  wire shortcut = sync2[6]; // Reduced dead time
  wire tri3 = sync2[7]; // Three-phase trip
  wire gen_blk = sync2[8]; // Device blocked

  // Settings array, word 0 is control
  logic [TW-1:0] cfg [0:15];

  // Processing tick prescaler
  logic [31:0] presc; // Cycle counter
  logic tick; // One-cycle tick

  // Shared tick for every sequence timer
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      presc <= '0;
      tick <= 1'b0;
    end else begin
      tick <= (presc == 32'(TICK_CYCLES - 1));
      // Wrap on the same compare so the period is exactly TICK_CYCLES
      presc <= (presc == 32'(TICK_CYCLES - 1)) ? '0 : presc + 32'h1;
    end
  end

  // Control fields
  wire op_en = cfg[0][CTRL_OP_BIT];
  wire sel_open = cfg[0][CTRL_SEL_BIT]; // 1: open starts dead
  wire [2:0] shot_req = cfg[0][CTRL_SHOT_LSB +: 3];
  // Codes above four mean all four
  wire [2:0] shot_lim = (shot_req > SHOT_MAX) ? SHOT_MAX : shot_req;

  // Anything here forces the sequencer idle
  wire inhibit = !op_en || blk_in || gen_blk
    || (shot_lim == 3'h0);

  // Sequencer state
  arc_state_t state, next_state;
  logic [1:0] shot, next_shot; // Shot index 0..3
  logic three_used, next_three; // Sticky three-phase

  // Timer control
  logic ld_main; // Reload main timer
  logic [3:0] main_idx; // Setting for main timer
  logic ld_close; // Start close and reclaim
  logic stop_all; // Abort close and reclaim
  logic main_exp, close_exp, rec_exp;
  logic main_run, close_run, rec_run;

  // Dead time setting for this shot
  wire use3 = three_used || tri3;
  wire [3:0] dead_idx = {1'b1, use3, shot};
  // Start condition chosen by setting
  wire start_cond = sel_open ? cb_open : !trip;
  // Room for another shot
  wire more_shots = ({1'b0, shot} + 3'h1) < shot_lim;
  wire restart = trip || pstart; // Pickup in reclaim

  // Next-state logic
  always_comb begin
    next_state = state;
    next_shot = shot;
    next_three = three_used;
    ld_main = 1'b0;
    main_idx = OFS_ACTION[5:2];
    ld_close = 1'b0;
    stop_all = 1'b0;
    if (inhibit) begin
      // Blocked: drop everything
      next_state = ST_IDLE;
      next_shot = 2'h0;
      next_three = 1'b0;
      stop_all = 1'b1;
    end else if (man_cl) begin
      // Manual close: hold off for set time
      next_state = ST_MANBLK;
      next_shot = 2'h0;
      next_three = 1'b0;
      ld_main = 1'b1;
      main_idx = OFS_MANUAL[5:2];
      stop_all = 1'b1;
    end else begin
      case (state)
        ST_IDLE: begin
          if (trip) begin
            // Trip at once skips the action wait
            next_state = ST_TRIP;
            ld_main = 1'b1;
            main_idx = OFS_MAXST[5:2];
          end else if (pstart) begin
            next_state = ST_ACTION;
            ld_main = 1'b1;
          end
        end
        ST_ACTION: begin
          if (trip) begin
            next_state = ST_TRIP;
            ld_main = 1'b1;
            main_idx = OFS_MAXST[5:2];
          end else if (main_exp) begin
            next_state = ST_DYNBLK;
            ld_main = 1'b1;
            main_idx = OFS_DYNBLK[5:2];
          end
        end
        ST_TRIP: begin
          if (tri3) begin
            next_three = 1'b1;
          end
          if (start_cond) begin
            next_state = ST_DEAD;
            ld_main = 1'b1;
            main_idx = dead_idx;
          end else if (main_exp) begin
            // Trip too long or breaker never opened
            next_state = ST_DYNBLK;
            ld_main = 1'b1;
            main_idx = OFS_DYNBLK[5:2];
          end
        end
        ST_DEAD: begin
          if (main_exp || shortcut) begin
            if (cb_ready) begin
              next_state = ST_RECLAIM;
              ld_close = 1'b1;
            end else begin
              next_state = ST_CBWAIT;
              ld_main = 1'b1;
              main_idx = OFS_CBTO[5:2];
            end
          end
        end
        ST_CBWAIT: begin
          if (cb_ready) begin
            next_state = ST_RECLAIM;
            ld_close = 1'b1;
          end else if (main_exp) begin
            next_state = ST_DYNBLK;
            ld_main = 1'b1;
            main_idx = OFS_DYNBLK[5:2];
          end
        end
        ST_RECLAIM: begin
          if (restart) begin
            stop_all = 1'b1;
            ld_main = 1'b1;
            if (!more_shots) begin
              // Last permitted shot failed
              next_state = ST_DYNBLK;
              main_idx = OFS_DYNBLK[5:2];
            end else if (trip) begin
              next_shot = shot + 2'h1;
              next_state = ST_TRIP;
              main_idx = OFS_MAXST[5:2];
            end else begin
              next_shot = shot + 2'h1;
              next_state = ST_ACTION;
            end
          end else if (rec_exp) begin
            // Fault cleared: next fault is shot one
            next_state = ST_IDLE;
            next_shot = 2'h0;
            next_three = 1'b0;
          end
        end
        ST_DYNBLK, ST_MANBLK: begin
          if (main_exp) begin
            next_state = ST_IDLE;
            next_shot = 2'h0;
            next_three = 1'b0;
          end
        end
        default: begin
          next_state = ST_IDLE;
        end
      endcase
    end
  end

  // State registers, general reset returns idle
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      state <= ST_IDLE;
      shot <= 2'h0;
      three_used <= 1'b0;
    end else begin
      state <= next_state;
      shot <= next_shot;
      three_used <= next_three;
    end
  end

  // Main phase timer, one phase at a time
  arc_timer #(.W(TW)) u_main (
    .i_ref_clk(i_ref_clk),
    .i_resetn(i_resetn),
    .i_tick(tick),
    .i_load(ld_main),
    .i_stop(inhibit),
    .i_value(cfg[main_idx]),
    .o_running(main_run),
    .o_expired(main_exp)
  );

  // Close pulse timer
  arc_timer #(.W(TW)) u_close (
    .i_ref_clk(i_ref_clk),
    .i_resetn(i_resetn),
    .i_tick(tick),
    .i_load(ld_close),
    .i_stop(stop_all),
    .i_value(cfg[OFS_CLOSE[5:2]]),
    .o_running(close_run),
    .o_expired(close_exp)
  );

  // Reclaim timer runs alongside the pulse
  arc_timer #(.W(TW)) u_reclaim (
    .i_ref_clk(i_ref_clk),
    .i_resetn(i_resetn),
    .i_tick(tick),
    .i_load(ld_close),
    .i_stop(stop_all),
    .i_value(cfg[OFS_RECLAIM[5:2]]),
    .o_running(rec_run),
    .o_expired(rec_exp)
  );

  // Status flops; decoded from next state to stay in step
  wire run_next = (next_state == ST_TRIP) || (next_state == ST_DEAD)
    || (next_state == ST_CBWAIT) || (next_state == ST_RECLAIM);

  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_close_command <= 1'b0;
      o_sequence_in_progress <= 1'b0;
      o_dynamic_blocked <= 1'b0;
      o_reclose_disabled <= 1'b0;
    end else begin
      // Pulse ends on expiry, trip or leaving reclaim
      if (ld_close) begin
        o_close_command <= 1'b1;
      end else if (close_exp || trip || next_state != ST_RECLAIM) begin
        o_close_command <= 1'b0;
      end
      o_sequence_in_progress <= run_next;
      o_dynamic_blocked <= (next_state == ST_DYNBLK);
      o_reclose_disabled <= inhibit || (next_state == ST_MANBLK);
    end
  end
  assign o_shot_number = shot;

  // Status word for software
  wire [31:0] status_word = 32'({three_used, o_close_command, o_dynamic_blocked,
    o_sequence_in_progress, 2'h0, shot, state});

  // Write channel holding registers
  logic aw_hold, w_hold;
  logic [AW-1:0] aw_addr;
  logic [15:0] w_data;
  logic [1:0] w_strb;
  assign o_s_axi_awready = !aw_hold && !o_s_axi_bvalid;
  assign o_s_axi_wready = !w_hold && !o_s_axi_bvalid;
  wire wr_go = aw_hold && w_hold && !o_s_axi_bvalid;
  wire [3:0] wr_idx = aw_addr[5:2];
  wire wr_cfg = aw_addr < OFS_STATUS; // Writable words
  wire wr_ok = aw_addr[6:2] <= OFS_STATUS[6:2]; // Status write ignored

  // Address and data taken in either order
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      aw_hold <= 1'b0;
      w_hold <= 1'b0;
      aw_addr <= '0;
      w_data <= '0;
      w_strb <= '0;
      o_s_axi_bvalid <= 1'b0;
      o_s_axi_bresp <= RESP_OKAY;
    end else begin
      if (i_s_axi_awvalid && o_s_axi_awready) begin
        aw_hold <= 1'b1;
        aw_addr <= i_s_axi_awaddr;
      end
      if (i_s_axi_wvalid && o_s_axi_wready) begin
        w_hold <= 1'b1;
        w_data <= i_s_axi_wdata[15:0];
        w_strb <= i_s_axi_wstrb[1:0];
      end
      if (wr_go) begin
        aw_hold <= 1'b0;
        w_hold <= 1'b0;
        o_s_axi_bvalid <= 1'b1;
        o_s_axi_bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (i_s_axi_bready) begin
        o_s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Settings store, only low two byte lanes exist
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      for (int i = 0; i < 16; i++) begin
        cfg[i] <= (i == 0) ? CTRL_RST : TIME_RST;
      end
    end else if (wr_go && wr_cfg) begin
      if (w_strb[0]) begin
        cfg[wr_idx][7:0] <= w_data[7:0];
      end
      if (w_strb[1]) begin
        cfg[wr_idx][15:8] <= w_data[15:8];
      end
    end
  end

  // Read decode
  wire [3:0] rd_idx = i_s_axi_araddr[5:2];
  wire rd_cfg = i_s_axi_araddr < OFS_STATUS;
  wire rd_stat = i_s_axi_araddr[6:2] == OFS_STATUS[6:2];
  wire [31:0] rd_word = rd_cfg ? {16'h0000, cfg[rd_idx]}
    : (rd_stat ? status_word : 32'h0000_0000);
  assign o_s_axi_arready = !o_s_axi_rvalid;

  // Read answers one cycle after the address
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_s_axi_rvalid <= 1'b0;
      o_s_axi_rdata <= '0;
      o_s_axi_rresp <= RESP_OKAY;
    end else if (i_s_axi_arvalid && o_s_axi_arready) begin
      o_s_axi_rvalid <= 1'b1;
      o_s_axi_rdata <= rd_word;
      o_s_axi_rresp <= (rd_cfg || rd_stat) ? RESP_OKAY : RESP_SLVERR;
    end else if (i_s_axi_rready) begin
      o_s_axi_rvalid <= 1'b0;
    end
  end

  // Checks on the sequence
  default clocking cb_main @(posedge i_ref_clk); endclocking
  default disable iff (!i_resetn);

  sequence s_dead_end;
    state == ST_DEAD && !inhibit && !man_cl && (main_exp || shortcut) && cb_ready;
  endsequence
  sequence s_close_on;
    o_close_command && state == ST_RECLAIM;
  endsequence

  a_action_no_trip: assert property (
    state == ST_ACTION && main_exp && !trip && !inhibit && !man_cl
    |=> state == ST_DYNBLK && o_dynamic_blocked)
    else $error("action expiry did not block");
  a_trip_runs: assert property (
    state == ST_ACTION && trip && !inhibit && !man_cl
    |=> o_sequence_in_progress && main_run)
    else $error("trip did not start run");
  a_dead_close: assert property (
    s_dead_end |=> s_close_on ##0 rec_run)
    else $error("dead end gave no close");
  a_close_cut: assert property (
    o_close_command && trip |=> !o_close_command)
    else $error("close not cut by trip");
  a_cb_timeout: assert property (
    state == ST_CBWAIT && main_exp && !cb_ready && !inhibit && !man_cl
    |=> state == ST_DYNBLK ##1 !o_close_command)
    else $error("breaker timeout not blocked");
  a_block_idle: assert property (
    inhibit |=> state == ST_IDLE && !o_close_command && shot == 2'h0)
    else $error("block left sequence running");
  a_manual_hold: assert property (
    man_cl && !inhibit |=> state == ST_MANBLK && o_reclose_disabled)
    else $error("manual close not held off");
  a_shot_limit: assert property (
    state == ST_RECLAIM && restart && !inhibit && !man_cl && !more_shots
    |=> state == ST_DYNBLK)
    else $error("shot beyond selection");
  a_reclaim_reset: assert property (
    state == ST_RECLAIM && rec_exp && !restart && !inhibit && !man_cl
    |=> state == ST_IDLE && shot == 2'h0 && !three_used)
    else $error("reclaim did not reset");
  a_three_sticky: assert property (
    three_used && state != ST_IDLE && !inhibit && !man_cl && next_state != ST_IDLE
    |=> three_used)
    else $error("three-phase memory lost");
  a_shortcut_end: assert property (
    state == ST_DEAD && shortcut && !inhibit && !man_cl
    |=> state == ST_RECLAIM || state == ST_CBWAIT)
    else $error("shortcut did not end dead time");
endmodule : arc_seq

// [arc_timer.sv]
`timescale 1ns/100ps
// Down counter of processing ticks
module arc_timer #(
  parameter int W = 16
) (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_resetn,
  // Control
  input wire logic i_tick,
  input wire logic i_load,
  input wire logic i_stop,
  input wire logic [W-1:0] i_value,
  // Status
  output logic o_running,
  output logic o_expired
);
  logic [W-1:0] count; // Ticks left

  // Load wins over stop so a restart is never lost
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      count <= '0;
      o_running <= 1'b0;
      o_expired <= 1'b0;
    end else begin
      o_expired <= 1'b0;
      if (i_load) begin
        count <= i_value;
        o_running <= 1'b1;
      end else if (i_stop) begin
        o_running <= 1'b0;
      end else if (o_running && i_tick) begin
        // Zero setting expires on the first tick
        if (count <= W'(1)) begin
          o_running <= 1'b0;
          o_expired <= 1'b1;
        end else begin
          count <= count - W'(1);
        end
      end
    end
  end
endmodule : arc_timer

// [tb.sv]
`timescale 1ns/100ps
// Bench for the reclosing sequencer
module tb;
  import arc_pkg::*;
  // Clock, reset and counters
  logic clk = 1'b0;
  logic rstn = 1'b0;
  int bad_count = 0;
  int n_tests = 0;
  // Bus master side
  logic awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
  logic [6:0] awa = 7'h00, ara = 7'h00;
  logic [31:0] wd = 32'h0;
  logic awr, wry, bv, arr, rv;
  logic [1:0] br, rrs;
  logic [31:0] rd;
  // Pins and partner control
  logic go = 1'b0, ntr = 1'b0, cbok = 1'b1, tph = 1'b0;
  logic blk = 1'b0, gblk = 1'b0, man = 1'b0, sc = 1'b0;
  logic st, tr, op, rdy, cls, run, dyn, dis;
  logic [1:0] shot;
  // Watched outputs by index
  logic [3:0] w;
  localparam int CL = 0, DY = 1, RU = 2;
  assign w = {dis, run, dyn, cls};
  // Free running 100 MHz clock
  always #5 clk = ~clk;
  // Short tick keeps timers brief
  arc_seq #(.TICK_CYCLES(4)) dut (
    .i_ref_clk(clk), .i_resetn(rstn),
    .i_s_axi_awvalid(awv), .o_s_axi_awready(awr), .i_s_axi_awaddr(awa),
    .i_s_axi_wvalid(wv), .o_s_axi_wready(wry), .i_s_axi_wdata(wd),
    .i_s_axi_wstrb(4'hf), .o_s_axi_bvalid(bv), .i_s_axi_bready(bry),
    .o_s_axi_bresp(br), .i_s_axi_arvalid(arv), .o_s_axi_arready(arr),
    .i_s_axi_araddr(ara), .o_s_axi_rvalid(rv), .i_s_axi_rready(rry),
    .o_s_axi_rdata(rd), .o_s_axi_rresp(rrs),
    .i_protection_start_in(st), .i_reclose_trigger_in(tr),
    .i_breaker_open_in(op), .i_breaker_ready_in(rdy),
    .i_reclose_block_in(blk), .i_manual_close_in(man),
    .i_dead_time_shortcut_in(sc), .i_three_phase_trip_in(tph),
    .i_general_block_in(gblk), .o_close_command(cls),
    .o_sequence_in_progress(run), .o_dynamic_blocked(dyn),
    .o_reclose_disabled(dis), .o_shot_number(shot)
  );
  // Line and breaker model
  arc_far_end far (
    .i_ref_clk(clk), .i_resetn(rstn), .i_go(go), .i_no_trip(ntr),
    .i_cb_ok(cbok), .i_close_command(cls), .o_start(st), .o_trip(tr),
    .o_open(op), .o_ready(rdy)
  );
  // Compare and count
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  task cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc
  // Write word, both channels offered together
  task wr(input logic [6:0] a, input logic [31:0] d, output logic [1:0] r);
    logic a_ok, w_ok, b_ok;
    @(posedge clk);
    awv <= 1'b1;
    wv <= 1'b1;
    awa <= a;
    wd <= d;
    bry <= 1'b1;
    while (1) begin
      // Sample settled values mid-cycle, act on the completing edge
      @(negedge clk);
      a_ok = awv && awr;
      w_ok = wv && wry;
      b_ok = bv;
      r = br;
      @(posedge clk);
      if (a_ok) awv <= 1'b0;
      if (w_ok) wv <= 1'b0;
      if (b_ok) break;
    end
    bry <= 1'b0;
  endtask : wr
  // Read word
  task rdw(input logic [6:0] a, output logic [31:0] d, output logic [1:0] r);
    logic a_ok, r_ok;
    @(posedge clk);
    arv <= 1'b1;
    ara <= a;
    rry <= 1'b1;
    while (1) begin
      @(negedge clk);
      a_ok = arv && arr;
      r_ok = rv;
      d = rd;
      r = rrs;
      @(posedge clk);
      if (a_ok) arv <= 1'b0;
      if (r_ok) break;
    end
    rry <= 1'b0;
  endtask : rdw
  task wrc(input logic [6:0] a, input logic [31:0] d);
    logic [1:0] r;
    wr(a, d, r);
    chk("write resp", 32'h0, {30'h0, r});
  endtask : wrc
  task rdc(input logic [6:0] a, input logic [31:0] e, input string nm);
    logic [31:0] d;
    logic [1:0] r;
    rdw(a, d, r);
    chk(nm, e, d);
    chk("read resp", 32'h0, {30'h0, r});
  endtask : rdc
  // One fault on the line
  task fault;
    @(posedge clk);
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
  endtask : fault
  // Bounded wait for an output level, sampled mid-cycle
  task wt(input int i, input logic v, input int lim, input string nm);
    int k;
    k = 0;
    @(negedge clk);
    while (w[i] !== v && k < lim) begin
      @(negedge clk);
      k++;
    end
    chk(nm, {31'h0, v}, {31'h0, w[i]});
    // Back on the rising edge for the next stimulus
    @(posedge clk);
  endtask : wt
  // Verdict and end of run
  task finish_test;
    $display("Checks %0d, mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : finish_test
  // Watchdog, far beyond the thousand or so cycles used
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    $display("CHECK FAILED watchdog exp done got hang");
    finish_test;
  end
  // Main sequence
  initial begin
    logic [31:0] d;
    logic [1:0] r;
    cyc(20);
    rstn <= 1'b1;
    cyc(2);
    rdc(OFS_CTRL, {16'h0, CTRL_RST}, "ctrl reset");
    rdc(OFS_ACTION, {16'h0, TIME_RST}, "time reset");
    rdc(OFS_STATUS, 32'h0, "status idle");
    rdw(7'h44, d, r);
    chk("unmapped resp", {30'h0, RESP_SLVERR}, {30'h0, r});
    chk("off disabled", 32'h1, {31'h0, dis});
    $display("test regs done");
    // Timer settings in ticks
    wrc(OFS_ACTION, 32'h5);
    wrc(OFS_MAXST, 32'ha);
    wrc(OFS_RECLAIM, 32'h1e);
    wrc(OFS_CBTO, 32'h5);
    wrc(OFS_DYNBLK, 32'ha);
    wrc(OFS_CLOSE, 32'h14);
    wrc(OFS_MANUAL, 32'ha);
    for (int i = 0; i < 8; i++) wrc(OFS_DEAD1P + 7'(4 * i), 32'h3);
    rdc(OFS_RECLAIM, 32'h1e, "reclaim readback");
    wrc(OFS_CTRL, 32'h1);
    cyc(5);
    chk("zero shots", 32'h1, {31'h0, dis});
    wrc(OFS_CTRL, 32'h5);
    // Two shots then exhaustion
    fault;
    wt(RU, 1'b1, 20, "run on trip");
    wt(CL, 1'b1, 300, "close one");
    chk("shot one", 32'h0, {30'h0, shot});
    cyc(10);
    fault;
    wt(CL, 1'b0, 20, "close cut");
    wt(CL, 1'b1, 300, "close two");
    chk("shot two", 32'h1, {30'h0, shot});
    cyc(10);
    fault;
    wt(DY, 1'b1, 100, "shots used");
    wt(DY, 1'b0, 100, "dyn over");
    $display("test shots done");
    // Pickup without trip
    ntr <= 1'b1;
    fault;
    wt(DY, 1'b1, 100, "no trip");
    chk("no close", 32'h0, {31'h0, cls});
    wt(DY, 1'b0, 100, "dyn over");
    ntr <= 1'b0;
    // Breaker never ready, open starts dead time
    wrc(OFS_CTRL, 32'h15);
    cbok <= 1'b0;
    fault;
    wt(DY, 1'b1, 300, "cb not ready");
    chk("no close", 32'h0, {31'h0, cls});
    wt(DY, 1'b0, 100, "dyn time");
    cbok <= 1'b1;
    $display("test timeouts done");
    // Huge dead time cut short
    wrc(OFS_DEAD1P, 32'hfff);
    fault;
    // Shortcut only once pickup and trip have gone
    cyc(20);
    sc <= 1'b1;
    wt(CL, 1'b1, 80, "shortcut");
    chk("fresh shot", 32'h0, {30'h0, shot});
    wt(CL, 1'b0, 100, "close timed");
    chk("reclaim after close", 32'h1, {31'h0, run});
    sc <= 1'b0;
    wt(RU, 1'b0, 300, "reclaim end");
    $display("test shortcut done");
    // Three-phase dead time, kept for the next shot
    wrc(OFS_DEAD1P + 7'h04, 32'hfff);
    tph <= 1'b1;
    fault;
    wt(CL, 1'b1, 100, "three-phase dead");
    cyc(10);
    tph <= 1'b0;
    fault;
    wt(CL, 1'b0, 20, "close cut three");
    wt(CL, 1'b1, 100, "three sticky");
    wt(RU, 1'b0, 300, "reclaim end three");
    $display("test three-phase done");
    // Local block, then general block
    for (int i = 0; i < 2; i++) begin
      blk <= (i == 0);
      gblk <= (i == 1);
      cyc(5);
      chk("blocked", 32'h1, {31'h0, dis});
      fault;
      cyc(40);
      chk("no run", 32'h0, {31'h0, run});
      blk <= 1'b0;
      gblk <= 1'b0;
      cyc(60);
    end
    // Manual close hold
    man <= 1'b1;
    cyc(3);
    man <= 1'b0;
    cyc(20);
    chk("manual hold", 32'h1, {31'h0, dis});
    cyc(60);
    chk("manual over", 32'h0, {31'h0, dis});
    $display("test blocks done");
    // General reset in mid sequence
    fault;
    wt(RU, 1'b1, 20, "run before reset");
    rstn <= 1'b0;
    cyc(2);
    rstn <= 1'b1;
    cyc(2);
    chk("reset idle", 32'h0, {31'h0, run});
    chk("reset off", 32'h1, {31'h0, dis});
    rdc(OFS_CTRL, {16'h0, CTRL_RST}, "ctrl after reset");
    $display("test reset done");
    finish_test;
  end
endmodule : tb
